// ==== logic/twd_pkg.sv ====
`default_nettype none
package twd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_REVID  = 8'h00;
  localparam logic [7:0] OFF_GPEN   = 8'h08;
  localparam logic [7:0] OFF_CNTLO  = 8'h10;
  localparam logic [7:0] OFF_CNTHI  = 8'h14;
  localparam logic [7:0] OFF_PRDLO  = 8'h18;
  localparam logic [7:0] OFF_PRDHI  = 8'h1c;
  localparam logic [7:0] OFF_TCR    = 8'h20;
  localparam logic [7:0] OFF_GCR    = 8'h24;
  localparam logic [7:0] OFF_WDCR   = 8'h28;
  localparam logic [7:0] OFF_RELLO  = 8'h34;
  localparam logic [7:0] OFF_RELHI  = 8'h38;
  localparam logic [7:0] OFF_ISTAT  = 8'h44;
  localparam logic [7:0] OFF_CMP0   = 8'h60;
  localparam logic [7:0] OFF_PWRREQ = 8'h80;
  // Field positions
  localparam int TCR_ENA_LO   = 6;
  localparam int TCR_ENA_HI   = 22;
  localparam int TCR_PWID     = 4;
  localparam int TCR_CP       = 3;
  localparam int TCR_INV      = 2;
  localparam int GCR_RS_LO    = 0;
  localparam int GCR_RS_HI    = 1;
  localparam int GCR_MODE     = 2;
  localparam int GCR_PLUS     = 4;
  localparam int WD_EN        = 14;
  localparam int WD_KEY       = 16;
  localparam int GP_ENO       = 17;
  localparam int GP_ENI       = 16;
  localparam int IS_PRD       = 1;
  localparam int IS_EVT       = 0;
  // Values
  localparam logic [1:0]  MODE_64    = 2'h0;
  localparam logic [1:0]  MODE_U32   = 2'h1;
  localparam logic [1:0]  MODE_WD    = 2'h2;
  localparam logic [1:0]  ENA_OFF    = 2'h0;
  localparam logic [1:0]  ENA_ONCE   = 2'h1;
  localparam logic [1:0]  ENA_RELOAD = 2'h3;
  localparam logic [15:0] KEY_ARM    = 16'ha5c6;
  localparam logic [15:0] KEY_FIRE   = 16'hda7e;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RST_PRD    = 32'hffff_ffff;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLV   = 2'b10;
  localparam int          NUM_CMP    = 8;
  // Watchdog states, Gray along the path
  typedef enum logic [1:0] {
    WD_OFF  = 2'b00,
    WD_PRE  = 2'b01,
    WD_ACT  = 2'b11,
    WD_TOUT = 2'b10
  } twd_wd_t;
endpackage
`default_nettype wire

// ==== logic/twd_top.sv ====
//How it works
//- Counter above period wraps through max
//- Active timer blocks counter/period/control writes
//- Watchdog off after reset, registers accessible
//- Watchdog needs mode 2 and enable
//- Watchdog uses internal clock, no one-shot
//- 64-bit match in watchdog resets processor
//- Enable plus A5C6 enters pre-active
//- Pre-active accepts control writes with key
//- DA7E with enable clears, goes active
//- A5C6 then DA7E services, clears counter
//- Any other key forces timeout immediately
//- Active watchdog cannot be disabled by software
//- Timeout clears enable, resets timer
//- Pre-active onward locks counter, period, control
//- Watchdog ignores power-down requests
//- Outside the active watchdog, run bit low freezes that half
//- Hardware reset restores all defaults
//- Period match raises interrupt and DMA
//- Extended mode compare match raises events
//- Output pin pulse or clock, width, invert
//- GPIO enable keeps low half in reset
//- Status flags clear on write one
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module twd_top #(
  parameter logic [31:0] REV_ID = 32'h0000_0001 // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_down_req,
  output logic             power_down_ack,
  output logic             cpu_interrupt_event,
  output logic             dma_request_event,
  output logic             timer_output_pin,
  output logic             proc_reset_req
);
  typedef twd_pkg::twd_wd_t twd_wd_st_t;

  logic [31:0] cnt_lo_q, cnt_hi_q, prd_lo_q, prd_hi_q, rel_lo_q, rel_hi_q;
  logic [31:0] tcr_q, gcr_q, gpen_q;
  logic [31:0] cmp_q [twd_pkg::NUM_CMP];
  logic        watchdog_enable_bit_q, armed_q, pwr_q;
  logic [1:0]  ist_q;
  twd_wd_st_t  wd_q;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        awv_q, wv_q;
  logic [2:0]  pw_cnt_q;
  logic        tstat_q;
  logic        int_q, dma_q, pin_q, rst_req_q;
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Decode
  wire         wr_go    = awv_q && wv_q && !s_axi_bvalid;
  wire [31:0]  wv       = w_q;
  wire [1:0]   mode     = gcr_q[twd_pkg::GCR_MODE +: 2];
  wire [1:0]   ena_lo   = tcr_q[twd_pkg::TCR_ENA_LO +: 2];
  wire [1:0]   ena_hi   = tcr_q[twd_pkg::TCR_ENA_HI +: 2];
  wire         rs_lo    = gcr_q[twd_pkg::GCR_RS_LO];
  wire         rs_hi    = gcr_q[twd_pkg::GCR_RS_HI];
  wire         plus     = gcr_q[twd_pkg::GCR_PLUS];
  wire         wd_mode  = (mode == twd_pkg::MODE_WD) && watchdog_enable_bit_q;
  wire         wd_lock  = (wd_q != twd_pkg::WD_OFF);
  wire         active   = (ena_lo != twd_pkg::ENA_OFF) || (ena_hi != twd_pkg::ENA_OFF);
  wire         gp_block = gpen_q[twd_pkg::GP_ENO] || gpen_q[twd_pkg::GP_ENI];
  wire         run_lo   = rs_lo && !gp_block;
  wire [63:0]  cnt64    = {cnt_hi_q, cnt_lo_q};
  wire [63:0]  prd64    = {prd_hi_q, prd_lo_q};
  wire         chain    = (mode != twd_pkg::MODE_U32);
  wire         wd_run   = (wd_q == twd_pkg::WD_ACT);
  wire         run64    = wd_run || (ena_lo != twd_pkg::ENA_OFF && run_lo && rs_hi);
  wire         hit64    = chain && run64 && (cnt64 == prd64);
  wire         hit_lo   = !chain && ena_lo != twd_pkg::ENA_OFF && run_lo && cnt_lo_q == prd_lo_q;
  wire         hit_hi   = !chain && ena_hi != twd_pkg::ENA_OFF && rs_hi && cnt_hi_q == prd_hi_q;
  wire         per_hit  = hit64 || hit_lo || hit_hi;
  logic        cmp_hit;
  always_comb begin
    cmp_hit = 1'b0;
    for (int i = 0; i < twd_pkg::NUM_CMP; i++) begin
      if (cnt_lo_q == cmp_q[i]) begin
        cmp_hit = 1'b1;
      end
    end
  end
  wire         ev_cmp   = plus && !chain && ena_lo != twd_pkg::ENA_OFF && run_lo && cmp_hit;

  // Key handling
  wire         wr_wd    = wr_go && aw_q == twd_pkg::OFF_WDCR;
  wire [15:0]  key      = wv[twd_pkg::WD_KEY +: 16];
  wire         key_wr   = wr_wd && ws_q[3:2] == 2'b11;
  wire         k_arm    = key_wr && key == twd_pkg::KEY_ARM;
  wire         k_fire   = key_wr && key == twd_pkg::KEY_FIRE;
  wire         k_bad    = key_wr && !k_arm && !k_fire && wd_lock;
  wire         serviced = wd_run && k_fire && armed_q;
  wire         wd_hit   = wd_run && (cnt64 == prd64);
  wire         tout_go  = (wd_hit || k_bad) && (wd_q == twd_pkg::WD_ACT || wd_q == twd_pkg::WD_PRE);
  wire         go_pre   = wd_q == twd_pkg::WD_OFF && watchdog_enable_bit_q && mode == twd_pkg::MODE_WD && k_arm;
  wire         go_act   = wd_q == twd_pkg::WD_PRE && k_fire && watchdog_enable_bit_q;
  wire         wr_en_ok = (wd_q == twd_pkg::WD_OFF) || (wd_q == twd_pkg::WD_PRE && (k_arm || k_fire));

  // Watchdog state machine
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wd_q      <= twd_pkg::WD_OFF;
      armed_q   <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= 1'b0;
      case (wd_q)
        twd_pkg::WD_OFF:  if (go_pre) begin
          wd_q <= twd_pkg::WD_PRE;
        end
        twd_pkg::WD_PRE:  if (tout_go) begin
          wd_q <= twd_pkg::WD_TOUT;
          rst_req_q <= 1'b1;
        end else if (go_act) begin
          wd_q <= twd_pkg::WD_ACT;
          armed_q <= 1'b0;
        end
        twd_pkg::WD_ACT:  if (tout_go) begin
          wd_q <= twd_pkg::WD_TOUT;
          rst_req_q <= 1'b1;
        end else if (k_arm) begin
          armed_q <= 1'b1;
        end else if (k_fire) begin
          armed_q <= 1'b0;
        end
        twd_pkg::WD_TOUT: wd_q <= twd_pkg::WD_OFF;
        default:          wd_q <= twd_pkg::WD_OFF;
      endcase
    end
  end

  // AXI write channel
  wire       lock_cnt = (active && !wd_lock) || wd_lock;
  wire       wr_ok_cnt = wr_go && !lock_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awv_q <= 1'b0;
      wv_q  <= 1'b0;
      aw_q  <= 8'h00;
      w_q   <= twd_pkg::RST_ZERO;
      ws_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= twd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awv_q <= 1'b1;
        aw_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wv_q <= 1'b1;
        w_q  <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        awv_q <= 1'b0;
        wv_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q > twd_pkg::OFF_PWRREQ) ? twd_pkg::RESP_SLV : twd_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awv_q && !s_axi_bvalid;
  assign s_axi_wready  = !wv_q && !s_axi_bvalid;

  // Control registers
  wire [31:0] tcr_new = merge(tcr_q, wv, ws_q);
  wire [31:0] gcr_new = merge(gcr_q, wv, ws_q) & ~({31'h0, gp_block} << twd_pkg::GCR_RS_LO);
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tcr_q  <= twd_pkg::RST_ZERO;
      gcr_q  <= twd_pkg::RST_ZERO;
      gpen_q <= twd_pkg::RST_ZERO;
      rel_lo_q <= twd_pkg::RST_ZERO;
      rel_hi_q <= twd_pkg::RST_ZERO;
      watchdog_enable_bit_q <= 1'b0;
      pwr_q  <= 1'b0;
      for (int i = 0; i < twd_pkg::NUM_CMP; i++) begin
        cmp_q[i] <= twd_pkg::RST_ZERO;
      end
    end else begin
      pwr_q <= power_down_req && !wd_mode && !wd_lock;
      if (wd_q == twd_pkg::WD_TOUT) begin
        watchdog_enable_bit_q <= 1'b0;
        tcr_q[twd_pkg::TCR_ENA_LO +: 2] <= twd_pkg::ENA_OFF;
        tcr_q[twd_pkg::TCR_ENA_HI +: 2] <= twd_pkg::ENA_OFF;
      end else if (wr_wd && wr_en_ok && ws_q[1]) begin
        watchdog_enable_bit_q <= wv[twd_pkg::WD_EN];
      end
      if (wr_go && aw_q == twd_pkg::OFF_TCR && !wd_lock) begin
        if (active) begin
          tcr_q[twd_pkg::TCR_ENA_LO +: 2] <= tcr_new[twd_pkg::TCR_ENA_LO +: 2];
          tcr_q[twd_pkg::TCR_ENA_HI +: 2] <= tcr_new[twd_pkg::TCR_ENA_HI +: 2];
        end else begin
          tcr_q <= tcr_new;
          if (gcr_q[twd_pkg::GCR_MODE +: 2] == twd_pkg::MODE_WD &&
              tcr_new[twd_pkg::TCR_ENA_LO +: 2] == twd_pkg::ENA_ONCE) begin
            tcr_q[twd_pkg::TCR_ENA_LO +: 2] <= twd_pkg::ENA_OFF;
          end
        end
      end
      if (wr_go && aw_q == twd_pkg::OFF_GCR) begin
        if (active || wd_lock) begin
          gcr_q[twd_pkg::GCR_RS_LO] <= gcr_new[twd_pkg::GCR_RS_LO];
          gcr_q[twd_pkg::GCR_RS_HI] <= gcr_new[twd_pkg::GCR_RS_HI];
        end else begin
          gcr_q <= gcr_new;
        end
      end
      if (wr_go && aw_q == twd_pkg::OFF_GPEN) begin
        gpen_q <= merge(gpen_q, wv, ws_q);
      end
      if (wr_go && aw_q == twd_pkg::OFF_RELLO) begin
        rel_lo_q <= merge(rel_lo_q, wv, ws_q);
      end
      if (wr_go && aw_q == twd_pkg::OFF_RELHI) begin
        rel_hi_q <= merge(rel_hi_q, wv, ws_q);
      end
      for (int i = 0; i < twd_pkg::NUM_CMP; i++) begin
        if (wr_go && aw_q == twd_pkg::OFF_CMP0 + 8'(4 * i)) begin
          cmp_q[i] <= merge(cmp_q[i], wv, ws_q);
        end
      end
    end
  end

  // Counters and period
  wire        clr_cnt = go_act || serviced || wd_q == twd_pkg::WD_TOUT;
  wire [63:0] cnt64_n = hit64 ? 64'h0 : cnt64 + 64'h1;
  wire        reload  = ena_lo == twd_pkg::ENA_RELOAD && !wd_mode;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_lo_q <= twd_pkg::RST_ZERO;
      cnt_hi_q <= twd_pkg::RST_ZERO;
      prd_lo_q <= twd_pkg::RST_PRD;
      prd_hi_q <= twd_pkg::RST_PRD;
    end else if (clr_cnt) begin
      cnt_lo_q <= twd_pkg::RST_ZERO;
      cnt_hi_q <= twd_pkg::RST_ZERO;
    end else begin
      if (chain && run64 && !(hit64 && ena_lo == twd_pkg::ENA_ONCE)) begin
        cnt_lo_q <= cnt64_n[31:0];
        cnt_hi_q <= cnt64_n[63:32];
        if (hit64 && reload) begin
          prd_lo_q <= rel_lo_q;
          prd_hi_q <= rel_hi_q;
        end
      end else if (!chain) begin
        if (ena_lo != twd_pkg::ENA_OFF && run_lo && !(hit_lo && ena_lo == twd_pkg::ENA_ONCE)) begin
          cnt_lo_q <= hit_lo ? twd_pkg::RST_ZERO : cnt_lo_q + 32'h1;
        end
        if (ena_hi != twd_pkg::ENA_OFF && rs_hi && !(hit_hi && ena_hi == twd_pkg::ENA_ONCE)) begin
          cnt_hi_q <= hit_hi ? twd_pkg::RST_ZERO : cnt_hi_q + 32'h1;
        end
      end
      if (wr_ok_cnt && aw_q == twd_pkg::OFF_CNTLO) begin
        cnt_lo_q <= merge(cnt_lo_q, wv, ws_q);
      end
      if (wr_ok_cnt && aw_q == twd_pkg::OFF_CNTHI) begin
        cnt_hi_q <= merge(cnt_hi_q, wv, ws_q);
      end
      if (wr_ok_cnt && aw_q == twd_pkg::OFF_PRDLO) begin
        prd_lo_q <= merge(prd_lo_q, wv, ws_q);
      end
      if (wr_ok_cnt && aw_q == twd_pkg::OFF_PRDHI) begin
        prd_hi_q <= merge(prd_hi_q, wv, ws_q);
      end
    end
  end

  // Events, status and output pin
  wire       ev_per  = per_hit && !wd_mode;
  wire       w1c_prd = wr_go && aw_q == twd_pkg::OFF_ISTAT && ws_q[0] && wv[twd_pkg::IS_PRD];
  wire       w1c_evt = wr_go && aw_q == twd_pkg::OFF_ISTAT && ws_q[0] && wv[twd_pkg::IS_EVT];
  wire [1:0] pwid    = tcr_q[twd_pkg::TCR_PWID +: 2];
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ist_q    <= 2'b00;
      int_q    <= 1'b0;
      dma_q    <= 1'b0;
      tstat_q  <= 1'b0;
      pw_cnt_q <= 3'h0;
      pin_q    <= 1'b0;
    end else begin
      ist_q[twd_pkg::IS_PRD] <= ev_per || (ist_q[twd_pkg::IS_PRD] && !w1c_prd);
      ist_q[twd_pkg::IS_EVT] <= ev_cmp || (ist_q[twd_pkg::IS_EVT] && !w1c_evt);
      int_q <= ev_per || ev_cmp;
      dma_q <= ev_per || ev_cmp;
      if (tcr_q[twd_pkg::TCR_CP]) begin
        if (ev_per) begin
          tstat_q <= !tstat_q;
        end
      end else if (ev_per) begin
        tstat_q  <= 1'b1;
        pw_cnt_q <= {1'b0, pwid};
      end else if (pw_cnt_q != 3'h0) begin
        pw_cnt_q <= pw_cnt_q - 3'h1;
      end else begin
        tstat_q <= 1'b0;
      end
      pin_q <= tstat_q ^ tcr_q[twd_pkg::TCR_INV];
    end
  end

  // AXI read channel
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = twd_pkg::RST_ZERO;
    case (s_axi_araddr)
      twd_pkg::OFF_REVID: rd_mux = REV_ID;
      twd_pkg::OFF_GPEN:  rd_mux = gpen_q;
      twd_pkg::OFF_CNTLO: rd_mux = cnt_lo_q;
      twd_pkg::OFF_CNTHI: rd_mux = cnt_hi_q;
      twd_pkg::OFF_PRDLO: rd_mux = prd_lo_q;
      twd_pkg::OFF_PRDHI: rd_mux = prd_hi_q;
      twd_pkg::OFF_TCR:   rd_mux = tcr_q;
      twd_pkg::OFF_GCR:   rd_mux = gcr_q;
      twd_pkg::OFF_WDCR:  rd_mux = {16'h0, 1'b0, watchdog_enable_bit_q, 12'h0, wd_q};
      twd_pkg::OFF_RELLO: rd_mux = rel_lo_q;
      twd_pkg::OFF_RELHI: rd_mux = rel_hi_q;
      twd_pkg::OFF_ISTAT: rd_mux = {30'h0, ist_q};
      default: begin
        if (s_axi_araddr >= twd_pkg::OFF_CMP0 && s_axi_araddr < twd_pkg::OFF_PWRREQ) begin
          rd_mux = cmp_q[s_axi_araddr[4:2]];
        end
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= twd_pkg::RST_ZERO;
      s_axi_rresp  <= twd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (s_axi_araddr >= twd_pkg::OFF_PWRREQ) ? twd_pkg::RESP_SLV : twd_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  assign cpu_interrupt_event = int_q;
  assign dma_request_event   = dma_q;
  assign timer_output_pin    = pin_q;
  assign proc_reset_req      = rst_req_q;
  assign power_down_ack      = pwr_q;

  a_tout_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    wd_q == twd_pkg::WD_TOUT |-> proc_reset_req ##1 !proc_reset_req)
    else $error("reset request not one clock on timeout");
  a_bad_key: assert property (@(posedge mclk) disable iff (!rst_b)
    (k_bad && wd_q == twd_pkg::WD_ACT) |=> wd_q == twd_pkg::WD_TOUT)
    else $error("bad key did not time out");
  a_enable_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    wd_q == twd_pkg::WD_TOUT |=> !watchdog_enable_bit_q)
    else $error("enable survived timeout");
  a_pwr_block: assert property (@(posedge mclk) disable iff (!rst_b)
    wd_lock |=> !power_down_ack)
    else $error("power down acknowledged in watchdog");
  a_wd_active: assert property (@(posedge mclk) disable iff (!rst_b)
    (wd_q == twd_pkg::WD_ACT && !tout_go) |=> wd_q == twd_pkg::WD_ACT)
    else $error("active watchdog left without timeout");
  a_serv_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    serviced && !tout_go |=> cnt_lo_q == 32'h0 && cnt_hi_q == 32'h0)
    else $error("service did not clear counter");
  a_flag_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    ev_per |=> ist_q[twd_pkg::IS_PRD])
    else $error("period flag lost");
  a_gpio_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (gp_block && !chain && !clr_cnt && !wr_go) |=> $stable(cnt_lo_q))
    else $error("low half ran with gpio enabled");
endmodule
`default_nettype wire

// ==== sim/twd_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module twd_far_model (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic cpu_interrupt_event,
  input  wire logic dma_request_event,
  input  wire logic proc_reset_req,
  input  wire logic timer_output_pin,
  input  wire logic pd_want,
  output var  logic power_down_req,
  output var  int   n_irq,
  output var  int   n_dma,
  output var  int   n_rst,
  output var  int   n_rst_hi,
  output var  int   n_pin
);
  logic rst_q;
  logic pin_q;
  // Sleep requests, event counts, reset pulse width
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      power_down_req <= 1'b0;
      n_irq          <= 0;
      n_dma          <= 0;
      n_rst          <= 0;
      n_rst_hi       <= 0;
      n_pin          <= 0;
      rst_q          <= 1'b0;
      pin_q          <= 1'b0;
    end else begin
      power_down_req <= pd_want;
      rst_q          <= proc_reset_req;
      pin_q          <= timer_output_pin;
      if (cpu_interrupt_event) n_irq <= n_irq + 1;
      if (dma_request_event) n_dma <= n_dma + 1;
      if (proc_reset_req && !rst_q) n_rst <= n_rst + 1;
      if (proc_reset_req) n_rst_hi <= n_rst_hi + 1;
      if (timer_output_pin != pin_q) n_pin <= n_pin + 1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/timer_watchdog_event_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module timer_watchdog_event_control_tb;
  localparam logic [31:0] REV = 32'h0000_0c3d; // Arbitrary value
  logic        mclk, rst_b, pd_want, power_down_req, power_down_ack;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        cpu_ev, dma_ev, pin, prst;
  int          num_errors, n_checks, n_irq, n_dma, n_rst, n_rst_hi, n_pin;
  int          p, e, i, i0, d0, t0, r0;

  twd_top #(.REV_ID(REV)) DUT (.mclk(mclk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .power_down_req(power_down_req),
    .power_down_ack(power_down_ack), .cpu_interrupt_event(cpu_ev),
    .dma_request_event(dma_ev), .timer_output_pin(pin), .proc_reset_req(prst));
  twd_far_model far (.mclk(mclk), .rst_b(rst_b), .cpu_interrupt_event(cpu_ev),
    .dma_request_event(dma_ev), .proc_reset_req(prst), .timer_output_pin(pin),
    .pd_want(pd_want), .power_down_req(power_down_req), .n_irq(n_irq),
    .n_dma(n_dma), .n_rst(n_rst), .n_rst_hi(n_rst_hi), .n_pin(n_pin));

  always #5 mclk = ~mclk;

  function automatic int exp_ev(input int w, input int prd);
    return w / (prd + 1);
  endfunction

  task automatic give_verdict;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int x, input int tol, input int g);
    n_checks++;
    if (g < x - tol || g > x + tol) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, x, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge mclk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t  = s_axi_wvalid & s_axi_wready;
      b_t  = s_axi_bvalid;
      @(posedge mclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
    end
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_t, r_t;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge mclk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t  = s_axi_rvalid;
      d    = s_axi_rdata;
      r    = s_axi_rresp;
      @(posedge mclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
    end
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    axi_rd(a, rd, rr);
    chk($sformatf("register %h", a), x, rd & m);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    {mclk, rst_b, pd_want, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h0;
    num_errors = 0;
    n_checks = 0;
    void'($urandom(32'hf0ba));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd_chk(twd_pkg::OFF_REVID, '1, REV);
    rd_chk(twd_pkg::OFF_CNTLO, '1, twd_pkg::RST_ZERO);
    rd_chk(twd_pkg::OFF_PRDLO, '1, twd_pkg::RST_PRD);
    rd_chk(twd_pkg::OFF_PRDHI, '1, twd_pkg::RST_PRD);
    rd_chk(twd_pkg::OFF_GCR, '1, twd_pkg::RST_ZERO);
    axi_rd(8'h84, rd, rr);
    chk("unmapped rresp", {30'h0, twd_pkg::RESP_SLV}, {30'h0, rr});
    axi_wr(twd_pkg::OFF_WDCR, 32'h0000_4000);
    axi_wr(twd_pkg::OFF_WDCR, 32'ha5c6_4000);
    rd_chk(twd_pkg::OFF_WDCR, 32'h0000_4003, 32'h0000_4000);
    // Low half frozen while its run bit is clear
    rv = $urandom;
    axi_wr(twd_pkg::OFF_CNTLO, rv);
    axi_wr(twd_pkg::OFF_TCR, 32'h0000_0080);
    repeat (20) @(posedge mclk);
    rd_chk(twd_pkg::OFF_CNTLO, '1, rv);
    axi_wr(twd_pkg::OFF_TCR, 32'h0);
    axi_wr(twd_pkg::OFF_GPEN, 32'h0002_0000);
    axi_wr(twd_pkg::OFF_GCR, 32'h0000_0005);
    rd_chk(twd_pkg::OFF_GCR, 32'h1, 32'h0);
    axi_wr(twd_pkg::OFF_GPEN, 32'h0);
    // Period events with clock-mode output
    p = 16 + int'($urandom % 16);
    axi_wr(twd_pkg::OFF_PRDLO, 32'(p));
    axi_wr(twd_pkg::OFF_PRDHI, 32'h0);
    axi_wr(twd_pkg::OFF_CNTLO, 32'h0);
    axi_wr(twd_pkg::OFF_GCR, 32'h0000_0003);
    axi_wr(twd_pkg::OFF_TCR, 32'h0000_0088);
    @(negedge mclk);
    i0 = n_irq;
    d0 = n_dma;
    t0 = n_pin;
    repeat (200) @(negedge mclk);
    e = exp_ev(200, p);
    chk_rng("interrupt events", e, 1, n_irq - i0);
    chk_rng("dma events", e, 1, n_dma - d0);
    chk_rng("pin edges", e, 1, n_pin - t0);
    @(posedge mclk);
    axi_wr(twd_pkg::OFF_PRDLO, 32'h5);
    rd_chk(twd_pkg::OFF_PRDLO, '1, 32'(p));
    axi_wr(twd_pkg::OFF_GCR, 32'h0000_0013);
    rd_chk(twd_pkg::OFF_GCR, 32'h10, 32'h0);
    axi_wr(twd_pkg::OFF_TCR, 32'h0);
    rd_chk(twd_pkg::OFF_ISTAT, 32'h2, 32'h2);
    axi_wr(twd_pkg::OFF_ISTAT, 32'h2);
    rd_chk(twd_pkg::OFF_ISTAT, 32'h2, 32'h0);
    // Compare and pulse events, unchained with extras on
    axi_wr(twd_pkg::OFF_CNTLO, 32'h0);
    axi_wr(twd_pkg::OFF_CMP0, 32'(p / 2));
    axi_wr(twd_pkg::OFF_GCR, 32'h0000_0015);
    axi_wr(twd_pkg::OFF_TCR, 32'h0000_00b0);
    @(negedge mclk);
    i0 = n_irq;
    t0 = n_pin;
    repeat (200) @(negedge mclk);
    chk_rng("compare events", exp_ev(600, p), 3, n_irq - i0);
    chk_rng("pulse edges", exp_ev(400, p), 3, n_pin - t0);
    @(posedge mclk);
    axi_wr(twd_pkg::OFF_TCR, 32'h0);
    rd_chk(twd_pkg::OFF_ISTAT, 32'h1, 32'h1);
    // Watchdog arming, service, bad key
    pd_want <= 1'b1;
    for (i = 0; i < 2; i++) begin
      axi_wr(twd_pkg::OFF_TCR, 32'h0);
      axi_wr(twd_pkg::OFF_GCR, 32'h0000_000b);
      axi_wr(twd_pkg::OFF_PRDLO, 32'd200);
      axi_wr(twd_pkg::OFF_CNTLO, 32'h0);
      axi_wr(twd_pkg::OFF_TCR, 32'h0000_0080);
      axi_wr(twd_pkg::OFF_WDCR, 32'h0000_4000);
      axi_wr(twd_pkg::OFF_WDCR, 32'ha5c6_4000);
      rd_chk(twd_pkg::OFF_WDCR, 32'h4003, 32'h4000 | 32'(twd_pkg::WD_PRE));
      axi_wr(twd_pkg::OFF_PRDLO, 32'h10);
      rd_chk(twd_pkg::OFF_PRDLO, '1, 32'd200);
      axi_wr(twd_pkg::OFF_WDCR, 32'hda7e_4000);
      r0 = n_rst;
      if (i == 0) begin
        rd_chk(twd_pkg::OFF_WDCR, 32'h4003, 32'h4000 | 32'(twd_pkg::WD_ACT));
        axi_wr(twd_pkg::OFF_WDCR, 32'ha5c6_0000);
        rd_chk(twd_pkg::OFF_WDCR, 32'h4003, 32'h4000 | 32'(twd_pkg::WD_ACT));
        repeat (3) begin
          repeat (120) @(posedge mclk);
          axi_wr(twd_pkg::OFF_WDCR, 32'ha5c6_4000);
          axi_wr(twd_pkg::OFF_WDCR, 32'hda7e_4000);
        end
        @(negedge mclk);
        chk("reset pulses", 32'(r0), 32'(n_rst));
        chk("sleep ack", 32'h0, {31'h0, power_down_ack});
        @(posedge mclk);
        axi_wr(twd_pkg::OFF_WDCR, 32'h1234_4000);
        repeat (3) @(negedge mclk);
        chk("reset pulses", 32'(r0 + 1), 32'(n_rst));
        chk("reset width", 32'(n_rst), 32'(n_rst_hi));
        @(posedge mclk);
        rd_chk(twd_pkg::OFF_WDCR, 32'h4003, 32'h0);
      end else begin
        for (t0 = 0; t0 < 400 && n_rst == r0; t0++) @(negedge mclk);
        chk_rng("expiry cycles", 200, 15, t0);
        chk("reset pulses", 32'(r0 + 1), 32'(n_rst));
        @(posedge mclk);
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
